// ### dv/sisr_cpu_model.sv
`timescale 1ns/1ps
module sisr_cpu_model
   import sisr_pkg::*;
(
   // clock and bus request
   input  wire logic    CLK,
   output sisr_bus_req_t REQ
);
   initial REQ = '0;
   // one strobe cycle, then the bus idles with inverted values
   task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge CLK);
      REQ <= '{a, d, w, !w};
      @(posedge CLK);
      REQ <= '{~a, ~d, 1'b0, 1'b0};
   endtask
endmodule

// ### dv/sisr_regs_assertions.sv
`timescale 1ns/1ps
module sisr_regs_chk
   import sisr_pkg::*;
(
   // watched ports
   input wire logic         CLK,
   input wire logic         SRST,
   input wire logic [15:0]  ADDR,
   input wire logic [7:0]   WDATA,
   input wire logic         WR,
   input wire logic         RD,
   input wire logic [7:0]   RDATA,
   input wire logic         OSCILLATOR_CLOCK,
   input wire logic         PLL_CLOCK,
   input wire logic         PLL_SELECT,
   input wire logic         BUS_CLOCK,
   input wire logic [127:1] IRQ_PENDING,
   input wire logic         BREAK_CLEAR_ENABLE,
   input wire logic         POWER_ON_RESET_IN,
   input wire logic         EXT_PIN_RESET,
   input wire logic         WATCHDOG_RESET,
   input wire logic         ILLEGAL_OPCODE_RESET,
   input wire logic         ILLEGAL_ADDRESS_RESET,
   input wire logic         LOW_VOLTAGE_RESET,
   input wire logic         INTERNAL_RESET
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not idle");
   rst_zero_a: assert property ($past(RD) && $past(ADDR) == 16'hFE01
      |-> RDATA[2] == 1'b0 && RDATA[0] == 1'b0) else $error("reset status bit set");
   irq_low_a: assert property (RD && ADDR == 16'hFE04 && !$past(SRST)
      |=> RDATA == {$past(IRQ_PENDING[6:1], 2), 2'b00}) else $error("irq low wrong");
   irq_mid_a: assert property (RD && ADDR == 16'hFE05 && !$past(SRST)
      |=> RDATA == $past(IRQ_PENDING[14:7], 2)) else $error("irq mid wrong");
   irq_high_a: assert property (RD && ADDR == 16'hFE06 && !$past(SRST)
      |=> RDATA == {5'h00, $past(IRQ_PENDING[17:15], 2)}) else $error("irq high wrong");
   bclk_hold_a: assert property (!$rose(PLL_SELECT ? PLL_CLOCK : OSCILLATOR_CLOCK)
      |=> $stable(BUS_CLOCK)) else $error("bus clock moved");
   bclk_toggle_a: assert property ($rose(PLL_SELECT ? PLL_CLOCK : OSCILLATOR_CLOCK)
      |=> $changed(BUS_CLOCK)) else $error("bus clock missed an edge");
   int_rst_a: assert property (INTERNAL_RESET == (POWER_ON_RESET_IN || EXT_PIN_RESET ||
      WATCHDOG_RESET || ILLEGAL_OPCODE_RESET || ILLEGAL_ADDRESS_RESET || LOW_VOLTAGE_RESET))
      else $error("internal reset wrong");
   bce_write_a: assert property (WR && ADDR == 16'hFE03
      |=> BREAK_CLEAR_ENABLE == $past(WDATA[7])) else $error("clear enable not written");
   bce_hold_a: assert property (!(WR && ADDR == 16'hFE03)
      |=> $stable(BREAK_CLEAR_ENABLE)) else $error("clear enable moved");
endmodule
bind sisr_regs sisr_regs_chk chk (.*);

// ### dv/sisr_regs_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
$display("ERROR %0t got %h exp %h", $time, g, e); end end
module system_integration_status_regs_tb_top
   import sisr_pkg::*;
;
   logic          clk = 0, srst = 1, osc = 0, pll = 0, psel = 0, brk = 0, bset = 0, rd_q = 0;
   logic [5:0]    src = '0;
   logic [127:1]  irq = '0;
   logic [127:0]  rnd;
   logic [7:0]    rdata, e, exp_q[$];
   logic [7:0]    rst_exp [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
   sisr_bus_req_t req;
   int            num_errors = 0, comparisons = 0, cyc = 0, seed = 74;
   sisr_cpu_model cpu (.CLK(clk), .REQ(req));
   sisr_regs uut (.CLK(clk), .SRST(srst), .ADDR(req.addr), .WDATA(req.wdata), .WR(req.wr),
      .RD(req.rd), .RDATA(rdata), .OSCILLATOR_CLOCK(osc), .PLL_CLOCK(pll),
      .PLL_SELECT(psel), .BUS_CLOCK(), .POWER_ON_RESET_IN(src[5]), .EXT_PIN_RESET(src[4]),
      .WATCHDOG_RESET(src[3]), .ILLEGAL_OPCODE_RESET(src[2]),
      .ILLEGAL_ADDRESS_RESET(src[1]), .LOW_VOLTAGE_RESET(src[0]), .INTERNAL_RESET(),
      .BREAK_ACTIVE(brk), .STOPWAIT_BREAK_SET(bset), .IRQ_PENDING(irq),
      .BREAK_CLEAR_ENABLE());
   initial forever #2 clk = ~clk;
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      cpu.xfer(a, 8'h00, 1'b0);
   endtask
   task automatic pulse();
      @(posedge clk) bset <= 1'b1;
      @(posedge clk) bset <= 1'b0;
   endtask
   // slow module clocks, timeout and read-data checker
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 0) osc <= ~osc;
      if (cyc % 6 == 0) pll <= ~pll;
      if (rd_q) begin
         e = exp_q.pop_front();
         `CHK(rdata, e)
      end
      rd_q <= req.rd;
      if (cyc > 2000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd(16'hFE01, 8'h80);
      rd(16'hFE03, 8'h00);
      rd(16'hFE02, 8'h00);
      cpu.xfer(16'hFE01, 8'hFF, 1'b1);
      cpu.xfer(16'hFE03, 8'hFF, 1'b1);
      rd(16'hFE01, 8'h80);
      rd(16'hFE03, 8'h80);
      repeat (4) begin
         rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
         irq <= rnd[127:1];
         psel <= ~psel;
         @(posedge clk);
         rd(16'hFE04, {rnd[6:1], 2'b00});
         rd(16'hFE05, rnd[14:7]);
         rd(16'hFE06, {5'h00, rnd[17:15]});
      end
      pulse();
      rd(16'hFE00, 8'h02);
      brk <= 1'b1;
      cpu.xfer(16'hFE00, 8'h00, 1'b1);
      rd(16'hFE00, 8'h00);
      pulse();
      cpu.xfer(16'hFE03, 8'h00, 1'b1);
      cpu.xfer(16'hFE00, 8'h00, 1'b1);
      rd(16'hFE00, 8'h02);
      brk <= 1'b0;
      cpu.xfer(16'hFE00, 8'hFD, 1'b1);
      rd(16'hFE00, 8'h00);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) src <= 6'h20 >> i;
         @(posedge clk) src <= 6'h00;
         rd(16'hFE01, rst_exp[i]);
      end
      repeat (3) @(posedge clk);
      report_and_stop();
   end
endmodule

// ### hw/sisr_clkdiv.sv
`timescale 1ns/1ps
`include "sisr_defs.svh"

// divides the module clock input by two with a toggle flop
module sisr_clkdiv
   import sisr_pkg::*;
(
   // clock and reset
   input  wire logic CLK,
   input  wire logic SRST,
   // clock input and divided output
   input  wire logic module_clock_in,
   output logic      bus_clock
);

   logic prev_ff;
   logic div_ff;
   logic nxt_prev;
   logic nxt_div;

   // module_clock_in is sampled; each of its rising edges toggles the output
   always_comb begin
      nxt_prev = module_clock_in;
      nxt_div  = div_ff;
      if (module_clock_in && !prev_ff) begin
         nxt_div = ~div_ff;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         prev_ff <= module_clock_in;   // no false edge right after reset
         div_ff  <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         div_ff  <= nxt_div;
      end
   end

   assign bus_clock = div_ff;

endmodule

// ### hw/sisr_defs.svh
`ifndef SISR_DEFS_SVH
`define SISR_DEFS_SVH

// register addresses on the internal address bus
`define SISR_ADDR_BRK_STAT    16'hFE00
`define SISR_ADDR_RST_STAT    16'hFE01
`define SISR_ADDR_BRK_CTRL    16'hFE03
`define SISR_ADDR_IRQ_LOW     16'hFE04
`define SISR_ADDR_IRQ_MID     16'hFE05
`define SISR_ADDR_IRQ_HIGH    16'hFE06
`define SISR_ADDR_BLK_BASE    16'hFE00

// field positions
`define SISR_BIT_SBW          1
`define SISR_BIT_BCE          7
`define SISR_BIT_POR          7
`define SISR_BIT_PIN          6
`define SISR_BIT_WDG          5
`define SISR_BIT_ILLEGAL_OPCODE_FLAG         4
`define SISR_BIT_ILLEGAL_ADDRESS_FLAG         3
`define SISR_BIT_LVD          1

// interrupt flag slicing (flag numbers 1..17)
`define SISR_IRQ_LOW_LSB      1
`define SISR_IRQ_MID_LSB      7
`define SISR_IRQ_HIGH_LSB     15
`define SISR_IRQ_SRC_MAX      128
`define SISR_IRQ_LOW_POS      2
`define SISR_IRQ_LOW_NUM      6
`define SISR_IRQ_MID_NUM      8
`define SISR_IRQ_HIGH_POS     0
`define SISR_IRQ_HIGH_NUM     3

// reset values
`define SISR_RST_BYTE         8'h00
`define SISR_POR_VALUE        8'h80

// module clock divide ratio (half count)
`define SISR_CLK_DIV          2

`endif

// ### hw/sisr_pkg.sv
package sisr_pkg;

   typedef struct packed {
      logic power_on;
      logic ext_pin;
      logic watchdog;
      logic illegal_opcode;
      logic illegal_address;
      logic low_voltage;
   } sisr_rst_src_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } sisr_bus_req_t;

   typedef enum logic [2:0] {
      SISR_SEL_NONE = 3'b000,
      SISR_SEL_BRK  = 3'b001,
      SISR_SEL_RST  = 3'b010,
      SISR_SEL_BCTL = 3'b011,
      SISR_SEL_IRQL = 3'b100,
      SISR_SEL_IRQM = 3'b101,
      SISR_SEL_IRQH = 3'b110
   } sisr_sel_t;

endpackage

// ### hw/sisr_regs.sv
// How it works
// - bus clock is the selected incoming module clock divided by two.
// - break status holds stop/wait break flag in bit 1; writing zero clears it.
// - reset status read-only, flags at bits 7,6,5,4,3,1; bits 2,0 zero.
// - after power-on reset only the power-on flag reads set.
// - break control bit 7 is read/write clear-enable, resets to zero.
// - first interrupt register shows flags 6..1 in bits 7..2, low bits zero.
// - second interrupt register shows flags 14..7 in bits 7..0.
// - third interrupt register shows flags 17..15 in bits 2..0, rest zero.
// - interrupt flag structure extends to 127 sources (flags 127..1).
// - without clear-enable, accesses in break leave protected flags unchanged.
`timescale 1ns/1ps
`include "sisr_defs.svh"

module sisr_regs
   import sisr_pkg::*;
(
   // clock and reset
   input  wire logic         CLK,
   input  wire logic         SRST,
   // register port
   input  wire logic [15:0]  ADDR,
   input  wire logic [7:0]   WDATA,
   input  wire logic         WR,
   input  wire logic         RD,
   output logic      [7:0]   RDATA,
   // clock sources
   input  wire logic         OSCILLATOR_CLOCK,
   input  wire logic         PLL_CLOCK,
   input  wire logic         PLL_SELECT,
   output logic              BUS_CLOCK,
   // reset sources
   input  wire logic         POWER_ON_RESET_IN,
   input  wire logic         EXT_PIN_RESET,
   input  wire logic         WATCHDOG_RESET,
   input  wire logic         ILLEGAL_OPCODE_RESET,
   input  wire logic         ILLEGAL_ADDRESS_RESET,
   input  wire logic         LOW_VOLTAGE_RESET,
   output logic              INTERNAL_RESET,
   // break and interrupts
   input  wire logic         BREAK_ACTIVE,
   input  wire logic         STOPWAIT_BREAK_SET,
   input  wire logic [127:1] IRQ_PENDING,
   output logic              BREAK_CLEAR_ENABLE
);

   sisr_bus_req_t req;
   sisr_rst_src_t rsrc_ff;
   sisr_rst_src_t nxt_rsrc;
   sisr_sel_t     sel;
   logic          sbw_ff;
   logic          nxt_sbw;
   logic          bce_ff;
   logic          nxt_bce;
   logic [7:0]    rdata_ff;
   logic [7:0]    nxt_rdata;
   logic [127:1]  irq_ff;
   logic [127:1]  nxt_irq;
   logic          any_rst;
   logic          clear_ok;
   logic          module_clock_in;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // address decode, shared by read and write paths
   function automatic sisr_sel_t decode(input logic [15:0] a);
      unique case (a)
         `SISR_ADDR_BRK_STAT: decode = SISR_SEL_BRK;
         `SISR_ADDR_RST_STAT: decode = SISR_SEL_RST;
         `SISR_ADDR_BRK_CTRL: decode = SISR_SEL_BCTL;
         `SISR_ADDR_IRQ_LOW:  decode = SISR_SEL_IRQL;
         `SISR_ADDR_IRQ_MID:  decode = SISR_SEL_IRQM;
         `SISR_ADDR_IRQ_HIGH: decode = SISR_SEL_IRQH;
         default:             decode = SISR_SEL_NONE;
      endcase
   endfunction

   assign sel = decode(req.addr);

   // clock selection feeding the divide-by-two
   assign module_clock_in = PLL_SELECT ? PLL_CLOCK : OSCILLATOR_CLOCK;

   sisr_clkdiv u_clkdiv (
      .CLK             (CLK),
      .SRST            (SRST),
      .module_clock_in (module_clock_in),
      .bus_clock       (BUS_CLOCK)
   );

   assign any_rst = POWER_ON_RESET_IN | EXT_PIN_RESET | WATCHDOG_RESET |
                    ILLEGAL_OPCODE_RESET | ILLEGAL_ADDRESS_RESET | LOW_VOLTAGE_RESET;
   assign INTERNAL_RESET = any_rst;

   // software may clear flags outside break, or in break when enabled
   assign clear_ok = !BREAK_ACTIVE || bce_ff;

   // reset source capture
   always_comb begin
      nxt_rsrc = rsrc_ff;
      if (POWER_ON_RESET_IN) begin
         nxt_rsrc = '{power_on: 1'b1, default: 1'b0};
      end else if (any_rst) begin
         nxt_rsrc = '{power_on:        1'b0,
                      ext_pin:         EXT_PIN_RESET,
                      watchdog:        WATCHDOG_RESET,
                      illegal_opcode:  ILLEGAL_OPCODE_RESET,
                      illegal_address: ILLEGAL_ADDRESS_RESET,
                      low_voltage:     LOW_VOLTAGE_RESET};
      end
   end

   // break flag and clear-enable
   always_comb begin
      nxt_sbw = sbw_ff;
      nxt_bce = bce_ff;
      if (req.wr && sel == SISR_SEL_BRK && !req.wdata[`SISR_BIT_SBW] && clear_ok) begin
         nxt_sbw = 1'b0;
      end
      if (STOPWAIT_BREAK_SET) begin
         nxt_sbw = 1'b1;   // set wins over clear
      end
      if (req.wr && sel == SISR_SEL_BCTL) begin
         nxt_bce = req.wdata[`SISR_BIT_BCE];
      end
   end

   // interrupt flags follow pending sources
   always_comb begin
      nxt_irq = IRQ_PENDING;
   end

   // read data, registered, valid the cycle after the strobe
   always_comb begin
      nxt_rdata = `SISR_RST_BYTE;
      if (req.rd) begin
         unique case (sel)
            SISR_SEL_BRK: begin
               nxt_rdata[`SISR_BIT_SBW] = sbw_ff;
            end
            SISR_SEL_RST: begin
               nxt_rdata[`SISR_BIT_POR]  = rsrc_ff.power_on;
               nxt_rdata[`SISR_BIT_PIN]  = rsrc_ff.ext_pin;
               nxt_rdata[`SISR_BIT_WDG]  = rsrc_ff.watchdog;
               nxt_rdata[`SISR_BIT_ILLEGAL_OPCODE_FLAG] = rsrc_ff.illegal_opcode;
               nxt_rdata[`SISR_BIT_ILLEGAL_ADDRESS_FLAG] = rsrc_ff.illegal_address;
               nxt_rdata[`SISR_BIT_LVD]  = rsrc_ff.low_voltage;
            end
            SISR_SEL_BCTL: begin
               nxt_rdata[`SISR_BIT_BCE] = bce_ff;
            end
            SISR_SEL_IRQL: begin
               nxt_rdata[`SISR_IRQ_LOW_POS +: `SISR_IRQ_LOW_NUM] =
                  irq_ff[`SISR_IRQ_LOW_LSB +: `SISR_IRQ_LOW_NUM];
            end
            SISR_SEL_IRQM: begin
               nxt_rdata = irq_ff[`SISR_IRQ_MID_LSB +: `SISR_IRQ_MID_NUM];
            end
            SISR_SEL_IRQH: begin
               nxt_rdata[`SISR_IRQ_HIGH_POS +: `SISR_IRQ_HIGH_NUM] =
                  irq_ff[`SISR_IRQ_HIGH_LSB +: `SISR_IRQ_HIGH_NUM];
            end
            SISR_SEL_NONE: begin
               nxt_rdata = `SISR_RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         rsrc_ff  <= '{power_on: 1'b1, default: 1'b0};
         sbw_ff   <= 1'b0;
         bce_ff   <= 1'b0;
         irq_ff   <= '0;
         rdata_ff <= `SISR_RST_BYTE;
      end else begin
         rsrc_ff  <= nxt_rsrc;
         sbw_ff   <= nxt_sbw;
         bce_ff   <= nxt_bce;
         irq_ff   <= nxt_irq;
         rdata_ff <= nxt_rdata;
      end
   end

   assign RDATA              = rdata_ff;
   assign BREAK_CLEAR_ENABLE = bce_ff;

endmodule
